// >>> hdl/sgmii_regs_pkg.sv
package sgmii_regs_pkg;

  // ==========================================================
  // Bus shape
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CONTROL     = 10'h000;
  localparam logic [9:0] IDX_AN_IRQ_CTRL = 10'h010;
  localparam logic [9:0] IDX_LB_POS_CTRL = 10'h011;
  localparam logic [9:0] IDX_EVT_STATUS  = 10'h020;
  localparam logic [9:0] IDX_EVT_MASK    = 10'h021;

  localparam logic [APB_AW-1:0] ADDR_CONTROL     = {IDX_CONTROL, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_AN_IRQ_CTRL = {IDX_AN_IRQ_CTRL, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_LB_POS_CTRL = {IDX_LB_POS_CTRL, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_EVT_STATUS  = {IDX_EVT_STATUS, 2'b00};
  localparam logic [APB_AW-1:0] ADDR_EVT_MASK    = {IDX_EVT_MASK, 2'b00};

  // ==========================================================
  // Field positions
  localparam int CTRL_LB_EN_BIT  = 14;
  localparam int AN_IRQ_EN_BIT   = 0;
  localparam int AN_IRQ_STAT_BIT = 1;
  localparam int LB_POS_BIT      = 0;
  localparam int EVT_AN_DONE_BIT = 0;
  localparam int EVT_LB_MOVE_BIT = 1;
  localparam int EVT_W           = 2;

  // ==========================================================
  // Values after reset
  localparam logic             LB_EN_RST    = 1'b0;
  localparam logic             AN_EN_RST    = 1'b1;
  localparam logic             AN_STAT_RST  = 1'b0;
  localparam logic             LB_POS_RST   = 1'b0;
  localparam logic [EVT_W-1:0] EVT_STAT_RST = 2'h0;
  localparam logic [EVT_W-1:0] EVT_MASK_RST = 2'h0;

  // ==========================================================
  // Cycle counts
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

endpackage

// >>> hdl/sync_rise.sv
module sync_rise (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic din,
  output logic      level,
  output logic      rise
);

  logic stage1;
  logic stage2;
  logic stage3;

  // ==========================================================
  // Two-flop synchroniser; only stage2 reads stage1
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~stage3;

endmodule

// >>> hdl/sgmii_an_irq_loopback_regs.sv
// How it works
// [R1] With the interrupt enabled, every completed auto-negotiation sets the status flag in bit 1 of the irq register.
// [R2] Once set, the flag stays set until software writes a zero to that bit or to the enable bit.
// [R3] While the enable bit is zero the flag is held at zero.
// [R4] The client interrupt output is the stored flag itself.
// [R5] Bit 0 of the irq register is a read/write enable that comes out of reset as one.
// [R6] Position bit zero puts enabled loopback inside the MAC, just ahead of the transceiver interface.
// [R7] Position bit one puts enabled loopback inside the serial transceiver.
// [R8] The position bit only chooses where; control bit 14 switches loopback on and off.
// [R9] The position bit starts from the static configuration attribute, not from a constant.
// [R10] Reserved bits read as zero and ignore writes.
module sgmii_an_irq_loopback_regs
  import sgmii_regs_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [APB_DW-1:0] pwdata,
  output logic      [APB_DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              anComplete,
  input  wire logic              loopback_position_default_attr,
  output logic                   autoneg_irq_out,
  output logic                   loopbackInMac,
  output logic                   loopbackInTransceiver,
  output logic                   irq
);

  // ==========================================================
  // State
  logic             loopEnable;
  logic             irqEnable;
  logic             loopPos;
  logic [EVT_W-1:0] evtStatus;
  logic [EVT_W-1:0] evtMask;
  logic [1:0]       captCnt;
  logic             captured;

  // ==========================================================
  // Synchronised pins
  logic anLevel;
  logic anRise;
  logic attrLevel;

  sync_rise u_an_sync (
    .mclk  (mclk),
    .nrst  (nrst),
    .din   (anComplete),
    .level (anLevel),
    .rise  (anRise)
  );

  sync_rise u_attr_sync (
    .mclk  (mclk),
    .nrst  (nrst),
    .din   (loopback_position_default_attr),
    .level (attrLevel),
    .rise  ()
  );

  // ==========================================================
  // Bus decode
  wire setupPhase = psel & ~penable;
  wire doWrite    = psel & penable & pready & pwrite;

  wire hitCtrl  = (paddr == ADDR_CONTROL);
  wire hitAn    = (paddr == ADDR_AN_IRQ_CTRL);
  wire hitLb    = (paddr == ADDR_LB_POS_CTRL);
  wire hitEvt   = (paddr == ADDR_EVT_STATUS);
  wire hitMask  = (paddr == ADDR_EVT_MASK);
  wire hitAny   = hitCtrl | hitAn | hitLb | hitEvt | hitMask;

  wire wrCtrl = doWrite & hitCtrl;
  wire wrAn   = doWrite & hitAn;
  wire wrLb   = doWrite & hitLb;
  wire wrEvt  = doWrite & hitEvt;
  wire wrMask = doWrite & hitMask;

  // ==========================================================
  // Next values
  wire next_irqEnable = wrAn ? pwdata[AN_IRQ_EN_BIT] : irqEnable; // [R5]

  // Only a written zero clears; a written one is ignored so software cannot fake completion
  wire anClearReq = wrAn & ~pwdata[AN_IRQ_STAT_BIT]; // [R2]

  // Set beats clear; a disabled interrupt always forces zero
  wire next_anFlag = next_irqEnable & (anRise | (autoneg_irq_out & ~anClearReq)); // [R1] [R2] [R3]

  // Attribute capture wins over a write racing it right after reset
  wire strapLoad = ~captured & (captCnt == STRAP_SETTLE);
  wire next_loopPos = strapLoad ? attrLevel : (wrLb ? pwdata[LB_POS_BIT] : loopPos); // [R9]

  wire next_loopEnable = wrCtrl ? pwdata[CTRL_LB_EN_BIT] : loopEnable; // [R8]

  wire lbMoved = (next_loopPos != loopPos) & next_loopEnable;

  wire [EVT_W-1:0] evtRaise;
  assign evtRaise[EVT_AN_DONE_BIT] = anRise;
  assign evtRaise[EVT_LB_MOVE_BIT] = lbMoved;

  wire [EVT_W-1:0] evtClear = wrEvt ? pwdata[EVT_W-1:0] : {EVT_W{1'b0}};
  wire [EVT_W-1:0] next_evtStatus = evtRaise | (evtStatus & ~evtClear);
  wire [EVT_W-1:0] next_evtMask   = wrMask ? pwdata[EVT_W-1:0] : evtMask;
  // Uses the mask as it will stand, so irq never lags a mask write
  wire next_irq = |(next_evtStatus & next_evtMask);

  // ==========================================================
  // Read mux, reserved bits zero
  wire [APB_DW-1:0] rdCtrl = {{(APB_DW-CTRL_LB_EN_BIT-1){1'b0}}, loopEnable, {CTRL_LB_EN_BIT{1'b0}}};
  wire [APB_DW-1:0] rdAn   = {{(APB_DW-2){1'b0}}, autoneg_irq_out, irqEnable}; // [R10]
  wire [APB_DW-1:0] rdLb   = {{(APB_DW-1){1'b0}}, loopPos}; // [R10]
  wire [APB_DW-1:0] rdEvt  = {{(APB_DW-EVT_W){1'b0}}, evtStatus};
  wire [APB_DW-1:0] rdMask = {{(APB_DW-EVT_W){1'b0}}, evtMask};

  wire [APB_DW-1:0] rdMux = hitCtrl ? rdCtrl :
                            hitAn   ? rdAn   :
                            hitLb   ? rdLb   :
                            hitEvt  ? rdEvt  :
                            hitMask ? rdMask : {APB_DW{1'b0}};

  // ==========================================================
  // Bus slave: one wait-free access phase
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase & ~hitAny;
      if (setupPhase) begin
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end

  // ==========================================================
  // Auto-negotiation interrupt
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irqEnable       <= AN_EN_RST; // [R5]
      autoneg_irq_out <= AN_STAT_RST;
    end else begin
      irqEnable       <= next_irqEnable;
      autoneg_irq_out <= next_anFlag; // [R4]
    end
  end

  // ==========================================================
  // Loopback control
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      captCnt  <= 2'h0;
      captured <= 1'b0;
    end else if (!captured) begin
      captCnt  <= captCnt + 2'h1;
      captured <= strapLoad;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      loopPos    <= LB_POS_RST;
      loopEnable <= LB_EN_RST;
    end else begin
      loopPos    <= next_loopPos;
      loopEnable <= next_loopEnable;
    end
  end

  // Outputs follow the stored bits one cycle later, so they never glitch on a write
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      loopbackInMac         <= 1'b0;
      loopbackInTransceiver <= 1'b0;
    end else begin
      loopbackInMac         <= loopEnable & ~loopPos; // [R6] [R8]
      loopbackInTransceiver <= loopEnable & loopPos; // [R7] [R8]
    end
  end

  // ==========================================================
  // Event status and mask
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      evtStatus <= EVT_STAT_RST;
      evtMask   <= EVT_MASK_RST;
      irq       <= 1'b0;
    end else begin
      evtStatus <= next_evtStatus;
      if (wrMask) begin
        evtMask <= pwdata[EVT_W-1:0];
      end
      irq <= next_irq;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_flag_sets_done: assert property ( // [R1]
    anRise && next_irqEnable |=> autoneg_irq_out
  ) else $error("flag not set on completed auto-negotiation");

  a_flag_holds_set: assert property ( // [R2]
    autoneg_irq_out && !(wrAn && !(pwdata[AN_IRQ_STAT_BIT] && pwdata[AN_IRQ_EN_BIT])) |=> autoneg_irq_out
  ) else $error("flag dropped without a software write");

  a_flag_zero_clear: assert property ( // [R2]
    wrAn && !pwdata[AN_IRQ_STAT_BIT] && !anRise |=> !autoneg_irq_out
  ) else $error("written zero did not clear the flag");

  a_disable_forces_zero: assert property ( // [R3]
    !irqEnable |-> !autoneg_irq_out
  ) else $error("flag set while interrupt disabled");

  a_out_matches_read: assert property ( // [R4]
    setupPhase && !pwrite && hitAn |=> prdata[AN_IRQ_STAT_BIT] == $past(autoneg_irq_out)
  ) else $error("read flag differs from interrupt output");

  a_enable_write_back: assert property ( // [R5]
    wrAn |=> irqEnable == $past(pwdata[AN_IRQ_EN_BIT])
  ) else $error("enable bit did not take written value");

  a_loop_in_mac: assert property ( // [R6]
    loopEnable && !loopPos |=> loopbackInMac && !loopbackInTransceiver
  ) else $error("loopback not placed in the MAC");

  a_loop_in_xcvr: assert property ( // [R7]
    loopEnable && loopPos |=> loopbackInTransceiver && !loopbackInMac
  ) else $error("loopback not placed in the transceiver");

  a_loop_off_idle: assert property ( // [R8]
    !loopEnable |=> !loopbackInMac && !loopbackInTransceiver
  ) else $error("loopback active while switched off");

  a_strap_loads_pos: assert property ( // [R9]
    strapLoad |=> loopPos == $past(attrLevel) ##1 captured
  ) else $error("position bit not loaded from attribute");

  a_reserved_read_zero: assert property ( // [R10]
    setupPhase && !pwrite && (hitAn || hitLb) |=> prdata[APB_DW-1:2] == 30'h0
  ) else $error("reserved bits read nonzero");

  a_irq_level_mask: assert property (
    |(evtStatus & evtMask) && !wrEvt && !wrMask |=> irq
  ) else $error("unmasked event did not raise irq");

  a_irq_matches_mask: assert property (
    irq == (|(evtStatus & evtMask))
  ) else $error("irq differs from masked status");

  a_ready_after_setup: assert property (
    setupPhase |=> pready
  ) else $error("no ready after setup");

  a_ready_single: assert property (
    pready |=> !pready
  ) else $error("ready held longer than one cycle");

  a_err_with_ready: assert property (
    pslverr |-> pready
  ) else $error("error without ready");

  a_slverr_unmapped: assert property (
    setupPhase && !hitAny |=> pslverr
  ) else $error("unmapped access not flagged");

  a_slverr_mapped: assert property (
    setupPhase && hitAny |=> !pslverr
  ) else $error("mapped access flagged as error");

  a_write_reads_zero: assert property (
    setupPhase && pwrite |=> prdata == 32'h0000_0000
  ) else $error("read data nonzero on a write");

  a_miss_reads_zero: assert property (
    setupPhase && !hitAny |=> prdata == 32'h0000_0000
  ) else $error("unmapped read nonzero");

  a_flag_needs_done: assert property ( // [R1]
    !autoneg_irq_out && !anRise |=> !autoneg_irq_out
  ) else $error("flag set without completion");

  a_set_beats_clear: assert property ( // [R1]
    anRise && wrAn && pwdata[AN_IRQ_EN_BIT] |=> autoneg_irq_out
  ) else $error("clear write hid a completion");

  a_disable_clears_flag: assert property ( // [R3]
    wrAn && !pwdata[AN_IRQ_EN_BIT] |=> !autoneg_irq_out && !irqEnable
  ) else $error("disabling left the flag set");

  a_enable_holds: assert property ( // [R5]
    !wrAn |=> $stable(irqEnable)
  ) else $error("enable changed without a write");

  a_an_read_enable: assert property ( // [R5]
    setupPhase && !pwrite && hitAn |=> prdata[AN_IRQ_EN_BIT] == $past(irqEnable)
  ) else $error("enable read back wrong");

  a_lb_en_write: assert property ( // [R8]
    wrCtrl |=> loopEnable == $past(pwdata[CTRL_LB_EN_BIT])
  ) else $error("loop enable did not take written value");

  a_lb_en_holds: assert property ( // [R8]
    !wrCtrl |=> $stable(loopEnable)
  ) else $error("loop enable changed without a write");

  a_pos_write_lands: assert property (
    wrLb && captured |=> loopPos == $past(pwdata[LB_POS_BIT])
  ) else $error("position bit did not take written value");

  a_pos_holds: assert property (
    captured && !wrLb |=> $stable(loopPos)
  ) else $error("position bit changed without a write");

  a_loop_exclusive: assert property ( // [R7]
    !(loopbackInMac && loopbackInTransceiver)
  ) else $error("loopback placed in two spots");

  a_lb_read_zero: assert property ( // [R10]
    setupPhase && !pwrite && hitLb |=> prdata[APB_DW-1:1] == 31'h0
  ) else $error("position register reserved bits nonzero");

  a_capture_sticky: assert property ( // [R9]
    captured |=> captured
  ) else $error("attribute captured more than once");

  a_evt_done_sets: assert property (
    anRise |=> evtStatus[EVT_AN_DONE_BIT]
  ) else $error("completion event not recorded");

  a_evt_done_w1c: assert property (
    wrEvt && pwdata[EVT_AN_DONE_BIT] && !anRise |=> !evtStatus[EVT_AN_DONE_BIT]
  ) else $error("completion event not cleared by one");

  a_evt_done_sticky: assert property (
    evtStatus[EVT_AN_DONE_BIT] && !wrEvt |=> evtStatus[EVT_AN_DONE_BIT]
  ) else $error("completion event dropped");

  a_move_event_sets: assert property (
    lbMoved |=> evtStatus[EVT_LB_MOVE_BIT]
  ) else $error("position move event not recorded");

  a_mask_write_lands: assert property (
    wrMask |=> evtMask == $past(pwdata[EVT_W-1:0])
  ) else $error("mask did not take written value");

endmodule

// >>> verification/sgmii_an_irq_loopback_regs_tb_top.sv
module sgmii_an_irq_loopback_regs_tb_top
  import sgmii_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Signals
  logic              mclk;
  logic              nrst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata;
  logic [APB_DW-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              anComplete;
  logic              strap;
  logic              anIrqOut;
  logic              inMac;
  logic              inXcvr;
  logic              irq;
  int                errors;
  int                n_compared;
  int                cycles;
  logic [APB_DW-1:0] rd;
  logic              err;

  sgmii_an_irq_loopback_regs u_dut (
    .mclk                           (mclk),
    .nrst                           (nrst),
    .psel                           (psel),
    .penable                        (penable),
    .pwrite                         (pwrite),
    .paddr                          (paddr),
    .pwdata                         (pwdata),
    .prdata                         (prdata),
    .pready                         (pready),
    .pslverr                        (pslverr),
    .anComplete                     (anComplete),
    .loopback_position_default_attr (strap),
    .autoneg_irq_out                (anIrqOut),
    .loopbackInMac                  (inMac),
    .loopbackInTransceiver          (inXcvr),
    .irq                            (irq)
  );

  // ==========================================================
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Ceiling sized well above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  // ==========================================================
  // Checks and expectations
  task automatic finish_test();
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t bit got %b expected %b", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] anWord(input logic en, input logic flag);
    return {30'h0, flag & en, en};
  endfunction

  // ==========================================================
  // Bus and pin drivers
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a slave that never answers
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [APB_AW-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp32(rd, exp);
  endtask

  // Pin is held well past the two-stage synchroniser
  task automatic pulse();
    @(posedge mclk) anComplete <= 1'b1;
    repeat (5) @(posedge mclk);
    anComplete <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  task automatic doReset(input logic s);
    @(posedge mclk);
    nrst  <= 1'b0;
    strap <= s;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic en;
    logic pos;
    logic [31:0] r;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    anComplete = 1'b0;
    strap = 1'b1;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    void'($urandom(74));
    doReset(1'b1);
    rdchk(ADDR_AN_IRQ_CTRL, anWord(1'b1, 1'b0));
    rdchk(ADDR_LB_POS_CTRL, 32'h1);
    cmp1(err, 1'b0);
    pulse();
    cmp1(anIrqOut, 1'b1);
    rdchk(ADDR_AN_IRQ_CTRL, anWord(1'b1, 1'b1));
    apb(1'b1, ADDR_AN_IRQ_CTRL, 32'hFFFFFFFF);
    rdchk(ADDR_AN_IRQ_CTRL, anWord(1'b1, 1'b1));
    apb(1'b1, ADDR_AN_IRQ_CTRL, {$urandom} & 32'hFFFFFFFD | 32'h1);
    rdchk(ADDR_AN_IRQ_CTRL, anWord(1'b1, 1'b0));
    cmp1(anIrqOut, 1'b0);
    pulse();
    apb(1'b1, ADDR_AN_IRQ_CTRL, 32'h2);
    rdchk(ADDR_AN_IRQ_CTRL, anWord(1'b0, 1'b1));
    pulse();
    rdchk(ADDR_AN_IRQ_CTRL, anWord(1'b0, 1'b1));
    cmp1(anIrqOut, 1'b0);
    for (int i = 0; i < 8; i++) begin
      en = i[1];
      pos = (i < 4) ? i[0] : 1'($urandom);
      apb(1'b1, ADDR_CONTROL, 32'(en) << CTRL_LB_EN_BIT);
      apb(1'b1, ADDR_LB_POS_CTRL, {$urandom} & 32'hFFFFFFFE | 32'(pos));
      rdchk(ADDR_LB_POS_CTRL, 32'(pos));
      cmp1(inMac, en & ~pos);
      cmp1(inXcvr, en & pos);
    end
    apb(1'b1, ADDR_AN_IRQ_CTRL, 32'h1);
    apb(1'b1, ADDR_EVT_MASK, 32'h1);
    apb(1'b1, ADDR_EVT_STATUS, 32'h3);
    repeat (2) @(posedge mclk);
    cmp1(irq, 1'b0);
    pulse();
    repeat (2) @(posedge mclk);
    cmp1(irq, 1'b1);
    apb(1'b1, ADDR_EVT_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    cmp1(irq, 1'b0);
    apb(1'b1, ADDR_EVT_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    cmp1(irq, 1'b1);
    apb(1'b1, ADDR_EVT_STATUS, 32'h1);
    repeat (2) @(posedge mclk);
    cmp1(irq, 1'b0);
    rdchk(ADDR_EVT_STATUS, 32'h0);
    rdchk(12'h0C0, 32'h0);
    cmp1(err, 1'b1);
    apb(1'b1, 12'h0C0, 32'hFFFFFFFF);
    cmp1(err, 1'b1);
    doReset(1'b0);
    rdchk(ADDR_LB_POS_CTRL, 32'h0);
    r = anWord(1'b1, 1'b0);
    rdchk(ADDR_AN_IRQ_CTRL, r);
    cmp1(anIrqOut, 1'b0);
    finish_test();
  end
endmodule
